// *** hdl/i2c_master_page_write.v ***
`timescale 1ns/1ps
// How it works
// - A page write opens like a byte write, with no stop after the first data byte.
// - With stop_after_write low the controller leaves the bus open after each byte.
// - A write of tx_data_reg launches the serial transfer by itself.
// - Writing tx_data_reg clears tx_empty_flag one clock later.
// - A new transaction begins with a start and the address byte before any data.
// - After the address byte the controller sends the tx_data_reg byte.
// - When a data byte is fully sent tx_empty_flag is set and an interrupt request raised.
// - A 32-byte page is 31 bytes with no stop, then a last byte with stop_after_write high.
// - With stop_after_write high a stop follows the byte, after tx_empty_flag is set.
`include "i2c_page_write_map.vh"

module i2c_master_page_write #(
  parameter QUARTER = `QUARTER_CYCLES
) (
  input wire mclk,
  input wire rst,
  input wire clkEnable,
  input wire [7:0] targetAddressIn,
  input wire targetAddressWrite,
  input wire [7:0] txDataIn,
  input wire txDataWrite,
  input wire stopAfterWrite,
  output reg txEmptyFlag,
  output reg txInterrupt,
  output reg ackError,
  output reg busOpen,
  input wire sclIn,
  output reg sclOut,
  output reg sclOe,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe
);

  localparam S_IDLE = 7'h01;
  localparam S_START = 7'h02;
  localparam S_BIT = 7'h04;
  localparam S_ACK = 7'h08;
  localparam S_DONE = 7'h10;
  localparam S_STOP = 7'h20;
  localparam S_HOLD = 7'h40;

  reg [6:0] state;
  reg [7:0] targetAddressReg;
  reg [7:0] txDataReg;
  reg [7:0] shiftReg;
  reg [3:0] bitCount;
  reg [1:0] phase;
  reg [15:0] tick;
  reg sendingAddress;
  reg sdaMeta;
  reg sdaSync;
  reg sclMeta;
  reg sclSync;
  wire quarterDone;

  assign quarterDone = (tick == (QUARTER[15:0] - 16'h0001));

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the bus lines come from outside this clock domain.
  always @(posedge mclk) begin
    if (rst) begin
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
    end else if (clkEnable) begin
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sclMeta <= sclIn;
      sclSync <= sclMeta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register side.
  always @(posedge mclk) begin
    if (rst) begin
      targetAddressReg <= `DATA_RESET;
    end else if (clkEnable && targetAddressWrite) begin
      targetAddressReg <= targetAddressIn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial engine. Each bit takes four quarters: low/set data, rise, high, fall.
  always @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      txDataReg <= `DATA_RESET;
      shiftReg <= `DATA_RESET;
      bitCount <= 4'h0;
      phase <= 2'h0;
      tick <= 16'h0000;
      sendingAddress <= 1'b0;
      txEmptyFlag <= 1'b1;
      txInterrupt <= 1'b0;
      ackError <= 1'b0;
      busOpen <= 1'b0;
      sclOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end else if (clkEnable) begin
      txInterrupt <= 1'b0;
      tick <= quarterDone ? 16'h0000 : tick + 16'h0001;
      case (state)
        S_IDLE, S_HOLD: begin
          tick <= 16'h0000;
          phase <= 2'h0;
          // Write launches transfer
          // A data write alone starts the engine.
          if (txDataWrite) begin
            txDataReg <= txDataIn;
            // Clear empty on write
            // The flag drops in the cycle after the write.
            txEmptyFlag <= 1'b0;
            bitCount <= 4'h0;
            // Start on new transaction
            // Only a closed bus sends start and address first.
            if (state == S_IDLE) begin
              state <= S_START;
              shiftReg <= targetAddressReg;
              sendingAddress <= 1'b1;
              // Lines are set high before the drivers turn on, so the first start has no false edge.
              sdaOut <= 1'b1;
              sclOut <= 1'b1;
            end else begin
              // Continue open transaction
              // An open bus skips start and address.
              state <= S_BIT;
              shiftReg <= txDataIn;
              sendingAddress <= 1'b0;
            end
          end
        end
        S_START: begin
          sdaOe <= 1'b1;
          sclOe <= 1'b1;
          busOpen <= 1'b1;
          if (quarterDone) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: begin
                sdaOut <= 1'b1;
                sclOut <= 1'b1;
              end
              2'h1: sdaOut <= 1'b0;
              2'h2: sclOut <= 1'b0;
              default: state <= S_BIT;
            endcase
          end
        end
        S_BIT, S_ACK: begin
          if (quarterDone) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: begin
                sdaOe <= (state == S_BIT);
                sdaOut <= shiftReg[7];
              end
              2'h1: sclOut <= 1'b1;
              2'h2: begin
                // Ninth clock acknowledge
                // Sample while the clock is high.
                if (state == S_ACK) begin
                  ackError <= sdaSync;
                end
              end
              default: begin
                sclOut <= 1'b0;
                if (state == S_ACK) begin
                  state <= S_DONE;
                end else if (bitCount == `BYTE_BITS - 4'h1) begin
                  state <= S_ACK;
                end else begin
                  bitCount <= bitCount + 4'h1;
                  shiftReg <= {shiftReg[6:0], 1'b0};
                end
              end
            endcase
          end
        end
        S_DONE: begin
          phase <= 2'h0;
          tick <= 16'h0000;
          bitCount <= 4'h0;
          if (sendingAddress) begin
            // Data after address
            // Address acknowledged, now the held data byte.
            sendingAddress <= 1'b0;
            shiftReg <= txDataReg;
            state <= S_BIT;
          end else begin
            // Byte sent flag
            // Empty flag and interrupt pulse together.
            txEmptyFlag <= 1'b1;
            txInterrupt <= 1'b1;
            // Stop only on request
            // Stop after the flag is set.
            // Page bytes pass with no stop.
            state <= stopAfterWrite ? S_STOP : S_HOLD;
          end
        end
        S_STOP: begin
          // The flag is already up here, so a write is taken and opens the next transaction.
          if (txDataWrite && txEmptyFlag) begin
            txDataReg <= txDataIn;
            txEmptyFlag <= 1'b0;
          end
          if (quarterDone) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: begin
                sdaOe <= 1'b1;
                sdaOut <= 1'b0;
              end
              2'h1: sclOut <= 1'b1;
              2'h2: sdaOut <= 1'b1;
              default: begin
                sdaOe <= 1'b0;
                sclOe <= 1'b0;
                busOpen <= 1'b0;
                if (txEmptyFlag && !txDataWrite) begin
                  state <= S_IDLE;
                end else begin
                  state <= S_START;
                  shiftReg <= targetAddressReg;
                  sendingAddress <= 1'b1;
                end
              end
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // i2c_master_page_write

// *** hdl/i2c_page_write_map.vh ***
`ifndef I2C_PAGE_WRITE_MAP_VH
`define I2C_PAGE_WRITE_MAP_VH

// Bus clock in kHz, a compile-time constant.
`define BUS_RATE_KHZ 400
// System clock in kHz.
`define MCLK_KHZ 100000
// Clock cycles per quarter of one serial clock period.
`define QUARTER_CYCLES ((`MCLK_KHZ / `BUS_RATE_KHZ) / 4)
// Bit position of the read/write bit in the target address.
`define ADDR_RW_BIT 0
// Reset value of transmit data and address.
`define DATA_RESET 8'h00
// Bits per byte on the wire.
`define BYTE_BITS 4'h8

`endif

// *** bench/i2c_master_page_write_checker.sv ***
`timescale 1ns/1ps
module i2c_master_page_write_checker (
  input wire mclk,
  input wire rst,
  input wire clkEnable,
  input wire txDataWrite,
  input wire stopAfterWrite,
  input wire txEmptyFlag,
  input wire txInterrupt,
  input wire busOpen,
  input wire sdaOut,
  input wire sdaOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // The bound also covers the default QUARTER, where a stop takes some 250 cycles.
  sequence stopSeq;
    busOpen ##[1:1000] !busOpen;
  endsequence
  empty_clear_a: assert property (txDataWrite && txEmptyFlag && clkEnable |=> !txEmptyFlag)
    else $error("busy not shown");
  empty_hold_a: assert property (txEmptyFlag && !txDataWrite |=> txEmptyFlag)
    else $error("launch without write");
  irq_empty_a: assert property (txInterrupt |-> txEmptyFlag)
    else $error("irq without empty");
  irq_pulse_a: assert property (txInterrupt |=> !txInterrupt)
    else $error("irq too long");
  open_hold_a: assert property (txInterrupt && !stopAfterWrite |=> busOpen [*8])
    else $error("bus closed early");
  stop_done_a: assert property (txInterrupt && stopAfterWrite |-> stopSeq)
    else $error("no stop");
  stop_level_a: assert property ($fell(busOpen) |-> $past(sdaOe) && $past(sdaOut) && !sdaOe)
    else $error("data low after stop");
  start_busy_a: assert property ($rose(busOpen) |-> !txEmptyFlag)
    else $error("start while idle");
endmodule // i2c_master_page_write_checker
bind i2c_master_page_write i2c_master_page_write_checker chk (.mclk, .rst, .clkEnable,
  .txDataWrite, .stopAfterWrite, .txEmptyFlag, .txInterrupt, .busOpen, .sdaOut, .sdaOe);

// *** bench/eeprom_model.sv ***
`timescale 1ns/1ps
module eeprom_model (
  input wire mclk,
  input wire scl,
  input wire sda,
  output logic ackLow,
  output logic got,
  output logic [7:0] data,
  output int starts,
  output int stops
);
  logic ps = 1, pd = 1;
  logic [7:0] sh;
  int n = 0;
  initial begin
    {ackLow, got} = 0;
    starts = 0;
    stops = 0;
  end
  always @(posedge mclk) begin
    ps <= scl;
    pd <= sda;
    got <= 0;
    if (scl && ps && pd && !sda) begin
      starts <= starts + 1;
      n <= 0;
    end else if (scl && ps && !pd && sda) stops <= stops + 1;
    else if (scl && !ps) begin
      sh <= {sh[6:0], sda};
      got <= n == 7;
      data <= {sh[6:0], sda};
      n <= n == 8 ? 0 : n + 1;
    end
    else if (!scl && ps) ackLow <= n == 8;
  end
endmodule // eeprom_model

// *** bench/i2c_master_page_write_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module i2c_master_page_write_bench;
  logic mclk = 0, rst = 1, clkEnable = 1, targetAddressWrite = 0, txDataWrite = 0;
  logic stopAfterWrite = 0;
  logic [7:0] targetAddressIn = 0, txDataIn = 0, data;
  wire txEmptyFlag, txInterrupt, ackError, busOpen, sclOut, sclOe, sdaOut, sdaOe, ackLow, got;
  wire scl = sclOe ? sclOut : 1'b1;
  wire sda = ackLow ? 1'b0 : sdaOe ? sdaOut : 1'b1;
  int n_errors = 0, num_checks = 0, cyc = 0, seed = 38703, starts, stops, sinceRise = 100;
  logic [7:0] q[$];
  logic [7:0] expected;
  logic sclWas = 1;
  wire [3:0] lineState = {sclOut, sdaOut, sdaOe, busOpen};
  localparam int quarter = 2;
  always #5 mclk = ~mclk;
  i2c_master_page_write #(.QUARTER(quarter)) uut (.mclk, .rst, .clkEnable, .targetAddressIn,
    .targetAddressWrite, .txDataIn, .txDataWrite, .stopAfterWrite, .txEmptyFlag, .txInterrupt,
    .ackError, .busOpen, .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda), .sdaOut, .sdaOe);
  eeprom_model mem (.mclk, .scl, .sda, .ackLow, .got, .data, .starts, .stops);
  task conclude;
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input logic [7:0] d, input logic last);
    logic [3:0] frozen;
    stopAfterWrite <= last;
    txDataIn <= d;
    txDataWrite <= 1;
    q.push_back(d);
    @(posedge mclk) txDataWrite <= 0;
    repeat (4) @(posedge mclk);
    // A write while busy must be ignored, so the wire still has to carry d.
    txDataIn <= ~d;
    txDataWrite <= 1;
    @(posedge mclk) begin
      txDataWrite <= 0;
      clkEnable <= 0;
    end
    @(negedge mclk) `CHK(txEmptyFlag, 1'b0)
    frozen = lineState;
    // With the clock enable low nothing on the wire may move.
    repeat (3) @(negedge mclk) `CHK(lineState, frozen)
    @(posedge mclk) clkEnable <= 1;
    for (int t = 0; t < 2000 && txInterrupt !== 1'b1; t++) @(negedge mclk);
    `CHK(txEmptyFlag, 1'b1)
    `CHK(ackError, 1'b0)
    @(posedge mclk);
  endtask
  task automatic page(input int n, input logic [7:0] a, input logic probe);
    @(posedge mclk);
    a[0] = 1'b0;
    targetAddressIn <= a;
    targetAddressWrite <= 1;
    q.push_back(a);
    @(posedge mclk) targetAddressWrite <= 0;
    // a probe sends memory address zero
    for (int i = 0; i < n + 2; i++)
      send(probe && i < 2 ? 8'h00 : 8'($random(seed)), i == n + 1);
    for (int t = 0; t < 100 && busOpen !== 1'b0; t++) @(negedge mclk);
    `CHK(busOpen, 1'b0)
  endtask
  // The expected byte is taken once, so a mismatch report cannot pop a second note.
  always @(negedge mclk) if (got) begin
    expected = q.pop_front();
    `CHK(data, expected)
  end
  // bit time: scl rises no faster than once per four quarters.
  always @(negedge mclk) begin
    sclWas <= scl;
    sinceRise <= (scl && !sclWas) ? 0 : sinceRise + 1;
    if (scl && !sclWas) `CHK(sinceRise >= 4 * quarter - 1, 1'b1)
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    page(32, 8'($random(seed)), 1'b0);
    page(1, 8'($random(seed)), 1'b0);
    // signature probe: target 0, then target 4, above the direction bit
    page(0, 8'h00, 1'b1);
    page(0, 8'h08, 1'b1);
    `CHK(starts, 4)
    `CHK(stops, 4)
    `CHK(q.size(), 0)
    conclude();
  end
endmodule // i2c_master_page_write_bench
